// ==== rtl/cmsf_pkg.sv ====
// package: register map, field masks, reset values and engine event carriers
package cmsf_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned MB_N   = 16;
   localparam int unsigned MB_W   = 4;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_PENDING   = 8'h00;
   localparam logic [7:0] OFS_CANCEL    = 8'h04;
   localparam logic [7:0] OFS_DIRECTION = 8'h08;
   localparam logic [7:0] OFS_TX_DONE   = 8'h0c;
   localparam logic [7:0] OFS_ABORT     = 8'h10;
   localparam logic [7:0] OFS_RX_DONE   = 8'h14;
   localparam logic [7:0] OFS_REMOTE    = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT  = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASK  = 8'h20;

   // ----------------------------------------------------------------
   // implemented bits and reset values
   // ----------------------------------------------------------------
   localparam logic [15:0] TX_MASK     = 16'hfffe;
   localparam logic [15:0] RX_MASK     = 16'hffff;
   localparam logic [15:0] MB0_RX_ONLY = 16'h0001;
   localparam logic [15:0] FLAG_RST    = 16'h0000;
   localparam logic [15:0] CTRL_RST    = 16'h0000;

   // ----------------------------------------------------------------
   // interrupt status and mask bit positions
   // ----------------------------------------------------------------
   localparam int unsigned IRQ_N      = 4;
   localparam int unsigned IRQ_TX     = 0;
   localparam int unsigned IRQ_ABORT  = 1;
   localparam int unsigned IRQ_RX     = 2;
   localparam int unsigned IRQ_REMOTE = 3;
   localparam logic [3:0]  IRQ_RST    = 4'h0;

   // ----------------------------------------------------------------
   // engine event carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic            vld;
      logic [MB_W-1:0] mb;
   } cmsf_tx_evt_t;

   typedef struct packed {
      logic            vld;
      logic [MB_W-1:0] mb;
      logic            remote;
   } cmsf_rx_evt_t;

endpackage : cmsf_pkg

// ==== rtl/cmsf_w1c_flags.sv ====
// sixteen sticky flags, set by hardware, cleared by writing 1
`timescale 1ns/1ps
module cmsf_w1c_flags #(
   parameter logic [15:0] IMPL_MASK = 16'hffff
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   // set and clear vectors
   input  wire logic [15:0] set_i,
   input  wire logic [15:0] clr_i,
   // flag state
   output logic      [15:0] flags_o
);

   logic [15:0] flags_q;
   logic [15:0] flags_d;

   // ----------------------------------------------------------------
   // next value: set wins over clear
   // ----------------------------------------------------------------
   always_comb begin
      flags_d = ((flags_q & ~clr_i) | set_i) & IMPL_MASK;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_q <= cmsf_pkg::FLAG_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags_o = flags_q;

endmodule : cmsf_w1c_flags

// ==== rtl/cmsf_top.sv ====
// mailbox transmit and receive status flags with register port and interrupt
`timescale 1ns/1ps
module cmsf_top (
   // clock and reset
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   // register port
   input  wire logic [7:0]             reg_addr_i,
   input  wire logic [15:0]            reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output logic      [15:0]            reg_rdata_o,
   // protocol engine events
   input  wire cmsf_pkg::cmsf_tx_evt_t tx_done_evt_i,
   input  wire cmsf_pkg::cmsf_tx_evt_t abort_evt_i,
   input  wire cmsf_pkg::cmsf_rx_evt_t rx_done_evt_i,
   // protocol engine control
   output logic      [15:0]            transmit_pending_o,
   output logic      [15:0]            transmit_cancel_request_o,
   output logic      [15:0]            mailbox_direction_o,
   // interrupt
   output logic                        irq_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] mb_onehot(input logic [3:0] mb, input logic vld);
      logic [15:0] v;
      v = 16'h0000;
      v[mb] = vld;
      return v;
   endfunction : mb_onehot

   function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs,
                                   input logic stb);
      return stb && (a == ofs);
   endfunction : wr_hit

   function automatic logic [15:0] clr_vec(input logic [7:0]  a,
                                           input logic [7:0]  ofs,
                                           input logic        stb,
                                           input logic [15:0] d);
      return wr_hit(a, ofs, stb) ? d : 16'h0000;
   endfunction : clr_vec

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [15:0] pending_q;
   logic [15:0] pending_d;
   logic [15:0] cancel_q;
   logic [15:0] cancel_d;
   logic [15:0] direction_q;
   logic [15:0] dir_eff;
   logic [15:0] tx_able;
   logic [15:0] tx_done_flags;
   logic [15:0] abort_flags;
   logic [15:0] rx_done_flags;
   logic [15:0] remote_flags;
   logic [15:0] tx_hit;
   logic [15:0] ab_hit;
   logic [15:0] rx_hit;
   logic [15:0] rf_hit;
   logic [15:0] finish;
   logic [15:0] clr_tx;
   logic [15:0] clr_ab;
   logic [15:0] clr_rx;
   logic [15:0] clr_rf;
   logic        wr_pending;
   logic        wr_cancel;
   logic        wr_direction;
   logic        wr_irq_mask;
   logic        rd_irq_stat;
   logic [3:0]  irq_stat_q;
   logic [3:0]  irq_stat_d;
   logic [3:0]  irq_mask_q;
   logic [3:0]  irq_evt;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   always_comb begin
      wr_pending   = wr_hit(reg_addr_i, cmsf_pkg::OFS_PENDING, reg_wr_i);
      wr_cancel    = wr_hit(reg_addr_i, cmsf_pkg::OFS_CANCEL, reg_wr_i);
      wr_direction = wr_hit(reg_addr_i, cmsf_pkg::OFS_DIRECTION, reg_wr_i);
      wr_irq_mask  = wr_hit(reg_addr_i, cmsf_pkg::OFS_IRQ_MASK, reg_wr_i);
      rd_irq_stat  = wr_hit(reg_addr_i, cmsf_pkg::OFS_IRQ_STAT, reg_rd_i);
      clr_tx = clr_vec(reg_addr_i, cmsf_pkg::OFS_TX_DONE, reg_wr_i, reg_wdata_i);
      clr_ab = clr_vec(reg_addr_i, cmsf_pkg::OFS_ABORT, reg_wr_i, reg_wdata_i);
      clr_rx = clr_vec(reg_addr_i, cmsf_pkg::OFS_RX_DONE, reg_wr_i, reg_wdata_i);
      clr_rf = clr_vec(reg_addr_i, cmsf_pkg::OFS_REMOTE, reg_wr_i, reg_wdata_i);
   end

   // ----------------------------------------------------------------
   // mailbox direction
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         direction_q <= cmsf_pkg::CTRL_RST;
      end else if (wr_direction) begin
         direction_q <= reg_wdata_i & cmsf_pkg::TX_MASK;
      end
   end

   // mailbox 0 always behaves as receiver
   assign dir_eff = direction_q | cmsf_pkg::MB0_RX_ONLY;

   // ----------------------------------------------------------------
   // transmit-capable mailboxes
   // ----------------------------------------------------------------
   assign tx_able = ~dir_eff & cmsf_pkg::TX_MASK;

   // ----------------------------------------------------------------
   // engine event qualification
   // ----------------------------------------------------------------
   always_comb begin
      // success only counts for a waiting transmit mailbox
      tx_hit = mb_onehot(tx_done_evt_i.mb, tx_done_evt_i.vld)
               & pending_q & tx_able;
      // cancel counts only if requested and not beaten by a send
      ab_hit = mb_onehot(abort_evt_i.mb, abort_evt_i.vld)
               & pending_q & cancel_q & ~tx_hit & cmsf_pkg::TX_MASK;
      // receptions land only in receive mailboxes
      rx_hit = mb_onehot(rx_done_evt_i.mb, rx_done_evt_i.vld)
               & dir_eff & cmsf_pkg::RX_MASK;
      rf_hit = rx_hit & {16{rx_done_evt_i.remote}};
      finish = tx_hit | ab_hit;
   end

   // ----------------------------------------------------------------
   // transmit pending
   // ----------------------------------------------------------------
   always_comb begin
      pending_d = pending_q & ~finish;
      if (wr_pending) begin
         pending_d = pending_d | (reg_wdata_i & tx_able);
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pending_q <= cmsf_pkg::CTRL_RST;
      end else begin
         pending_q <= pending_d;
      end
   end

   // ----------------------------------------------------------------
   // transmit cancel request
   // ----------------------------------------------------------------
   always_comb begin
      // request drops when its message is gone either way
      cancel_d = cancel_q & pending_q & ~finish;
      if (wr_cancel) begin
         cancel_d = cancel_d | (reg_wdata_i & pending_q & ~finish & cmsf_pkg::TX_MASK);
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cancel_q <= cmsf_pkg::CTRL_RST;
      end else begin
         cancel_q <= cancel_d;
      end
   end

   // ----------------------------------------------------------------
   // completion flag registers
   // ----------------------------------------------------------------
   cmsf_w1c_flags #(
      .IMPL_MASK (cmsf_pkg::TX_MASK)
   ) u_tx_done (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (tx_hit),
      .clr_i     (clr_tx),
      .flags_o   (tx_done_flags)
   );

   cmsf_w1c_flags #(
      .IMPL_MASK (cmsf_pkg::TX_MASK)
   ) u_abort_done (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (ab_hit),
      .clr_i     (clr_ab),
      .flags_o   (abort_flags)
   );

   cmsf_w1c_flags #(
      .IMPL_MASK (cmsf_pkg::RX_MASK)
   ) u_rx_done (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (rx_hit),
      .clr_i     (clr_rx),
      .flags_o   (rx_done_flags)
   );

   cmsf_w1c_flags #(
      .IMPL_MASK (cmsf_pkg::RX_MASK)
   ) u_remote (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .set_i     (rf_hit),
      .clr_i     (clr_rf),
      .flags_o   (remote_flags)
   );

   // ----------------------------------------------------------------
   // interrupt status
   // ----------------------------------------------------------------
   always_comb begin
      irq_evt = 4'h0;
      irq_evt[cmsf_pkg::IRQ_TX]     = |tx_hit;
      irq_evt[cmsf_pkg::IRQ_ABORT]  = |ab_hit;
      irq_evt[cmsf_pkg::IRQ_RX]     = |rx_hit;
      irq_evt[cmsf_pkg::IRQ_REMOTE] = |rf_hit;
      // read clears, new event in same cycle survives
      irq_stat_d = (rd_irq_stat ? 4'h0 : irq_stat_q) | irq_evt;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_stat_q <= cmsf_pkg::IRQ_RST;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // ----------------------------------------------------------------
   // interrupt mask
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_mask_q <= cmsf_pkg::IRQ_RST;
      end else if (wr_irq_mask) begin
         irq_mask_q <= reg_wdata_i[3:0];
      end
   end

   // ----------------------------------------------------------------
   // interrupt output
   // ----------------------------------------------------------------
   assign irq_o = |(irq_stat_q & irq_mask_q);

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always_comb begin
      rdata_d = 16'h0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            cmsf_pkg::OFS_PENDING:   rdata_d = pending_q;
            cmsf_pkg::OFS_CANCEL:    rdata_d = cancel_q;
            cmsf_pkg::OFS_DIRECTION: rdata_d = dir_eff;
            cmsf_pkg::OFS_TX_DONE:   rdata_d = tx_done_flags;
            cmsf_pkg::OFS_ABORT:     rdata_d = abort_flags;
            cmsf_pkg::OFS_RX_DONE:   rdata_d = rx_done_flags;
            cmsf_pkg::OFS_REMOTE:    rdata_d = remote_flags;
            cmsf_pkg::OFS_IRQ_STAT:  rdata_d = {12'h000, irq_stat_q};
            cmsf_pkg::OFS_IRQ_MASK:  rdata_d = {12'h000, irq_mask_q};
            default:                 rdata_d = 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read data register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign reg_rdata_o               = rdata_q;
   assign transmit_pending_o        = pending_q;
   assign transmit_cancel_request_o = cancel_q;
   assign mailbox_direction_o       = dir_eff;

endmodule : cmsf_top

// ==== bench/cmsf_top_asserts.sv ====
// checker: concurrent properties on the flag block ports
`timescale 1ns/1ps
module cmsf_top_asserts (
   // clock and reset
   input wire logic                   sys_clk_i,
   input wire logic                   nrst_i,
   // register port
   input wire logic [7:0]             reg_addr_i,
   input wire logic [15:0]            reg_wdata_i,
   input wire logic                   reg_wr_i,
   input wire logic                   reg_rd_i,
   input wire logic [15:0]            reg_rdata_o,
   // engine events
   input wire cmsf_pkg::cmsf_tx_evt_t tx_done_evt_i,
   input wire cmsf_pkg::cmsf_tx_evt_t abort_evt_i,
   input wire cmsf_pkg::cmsf_rx_evt_t rx_done_evt_i,
   // control and interrupt
   input wire logic [15:0]            transmit_pending_o,
   input wire logic [15:0]            transmit_cancel_request_o,
   input wire logic [15:0]            mailbox_direction_o,
   input wire logic                   irq_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   wire logic pnd_wr = reg_wr_i && reg_addr_i == 8'h00;

   tx_clr_a: assert property (
      tx_done_evt_i.vld && transmit_pending_o[tx_done_evt_i.mb] && !pnd_wr &&
      !mailbox_direction_o[tx_done_evt_i.mb] |=> !transmit_pending_o[$past(tx_done_evt_i.mb)])
      else $error("pending kept after send");
   abort_clr_a: assert property (
      abort_evt_i.vld && transmit_pending_o[abort_evt_i.mb] && !pnd_wr &&
      transmit_cancel_request_o[abort_evt_i.mb] &&
      !(tx_done_evt_i.vld && tx_done_evt_i.mb == abort_evt_i.mb)
      |=> !transmit_pending_o[$past(abort_evt_i.mb)] &&
      !transmit_cancel_request_o[$past(abort_evt_i.mb)])
      else $error("pending or cancel kept after abort");
   pend_set_a: assert property (
      pnd_wr |=> (($past(reg_wdata_i) & ~$past(mailbox_direction_o) & 16'hfffe)
      & ~transmit_pending_o) == 16'h0000)
      else $error("pending write lost");
   pend_hold_a: assert property (
      !tx_done_evt_i.vld && !abort_evt_i.vld |=>
      (transmit_pending_o & $past(transmit_pending_o)) == $past(transmit_pending_o))
      else $error("pending cleared without event");
   cancel_sub_a: assert property (
      (transmit_cancel_request_o & ~transmit_pending_o
      & ~$past(transmit_pending_o)) == 16'h0000)
      else $error("cancel set without pending");
   mb0_tx_a: assert property (
      !transmit_pending_o[0] && !transmit_cancel_request_o[0])
      else $error("mailbox 0 transmit bit set");
   mb0_dir_a: assert property (
      mailbox_direction_o[0])
      else $error("mailbox 0 not receiver");
   rdata_idle_a: assert property (
      !reg_rd_i |=> reg_rdata_o == 16'h0000)
      else $error("read data outside read cycle");
endmodule : cmsf_top_asserts

bind cmsf_top cmsf_top_asserts u_cmsf_top_asserts (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .tx_done_evt_i(tx_done_evt_i),
   .abort_evt_i(abort_evt_i), .rx_done_evt_i(rx_done_evt_i),
   .transmit_pending_o(transmit_pending_o),
   .transmit_cancel_request_o(transmit_cancel_request_o),
   .mailbox_direction_o(mailbox_direction_o), .irq_o(irq_o));

// ==== bench/cmsf_engine_model.sv ====
// partner model: protocol engine reporting send, abort and receive events
`timescale 1ns/1ps
module cmsf_engine_model (
   // clock
   input  wire logic              sys_clk_i,
   // events
   output cmsf_pkg::cmsf_tx_evt_t tx_done_evt_o,
   output cmsf_pkg::cmsf_tx_evt_t abort_evt_o,
   output cmsf_pkg::cmsf_rx_evt_t rx_done_evt_o
);
   initial begin
      tx_done_evt_o = '0;
      abort_evt_o   = '0;
      rx_done_evt_o = '0;
   end

   task automatic send(input logic [3:0] mb);
      @(posedge sys_clk_i);
      tx_done_evt_o <= '{vld: 1'b1, mb: mb};
      @(posedge sys_clk_i);
      tx_done_evt_o <= '{vld: 1'b0, mb: ~mb};
      #1;
   endtask : send

   task automatic abort(input logic [3:0] mb);
      @(posedge sys_clk_i);
      abort_evt_o <= '{vld: 1'b1, mb: mb};
      @(posedge sys_clk_i);
      abort_evt_o <= '{vld: 1'b0, mb: ~mb};
      #1;
   endtask : abort

   task automatic recv(input logic [3:0] mb, input logic rem);
      @(posedge sys_clk_i);
      rx_done_evt_o <= '{vld: 1'b1, mb: mb, remote: rem};
      @(posedge sys_clk_i);
      rx_done_evt_o <= '{vld: 1'b0, mb: ~mb, remote: ~rem};
      #1;
   endtask : recv
endmodule : cmsf_engine_model

// ==== bench/cmsf_top_test.sv ====
// testbench: register and event sequences for the mailbox flag block
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
   $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module cmsf_top_test;
   logic                   sys_clk_i;
   logic                   nrst_i;
   logic [7:0]             addr;
   logic [15:0]            wdata;
   logic                   wr;
   logic                   rd;
   logic [15:0]            rdata, pend, canc, dir;
   logic                   irq;
   cmsf_pkg::cmsf_tx_evt_t tx_evt, ab_evt;
   cmsf_pkg::cmsf_rx_evt_t rx_evt;
   int                     error_cnt = 0;
   int                     tests_run = 0;

   initial begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   cmsf_engine_model u_cmsf_engine_model (.sys_clk_i(sys_clk_i), .tx_done_evt_o(tx_evt),
      .abort_evt_o(ab_evt), .rx_done_evt_o(rx_evt));
   cmsf_top u_cmsf_top (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .tx_done_evt_i(tx_evt), .abort_evt_i(ab_evt), .rx_done_evt_i(rx_evt),
      .transmit_pending_o(pend), .transmit_cancel_request_o(canc),
      .mailbox_direction_o(dir), .irq_o(irq));

   task automatic finish_test;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge sys_clk_i);
      wr <= 1'b0;
      #1;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
      @(posedge sys_clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge sys_clk_i);
      rd <= 1'b0;
      #1;
      `CHK($sformatf("rdata %h", a), e, rdata)
   endtask : rd_reg

   initial begin
      repeat (5000) @(posedge sys_clk_i);
      error_cnt++;
      finish_test();
   end

   initial begin
      nrst_i <= 1'b0;
      addr   <= 8'h00;
      wdata  <= 16'h0000;
      wr     <= 1'b0;
      rd     <= 1'b0;
      repeat (6) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      #1;
      `CHK("pend", 16'h0000, pend)
      `CHK("canc", 16'h0000, canc)
      `CHK("dir", 16'h0001, dir)
      for (int i = 0; i < 8; i++) rd_reg(8'(i * 4), (i == 2) ? 16'h0001 : 16'h0000);
      wr_reg(8'h08, 16'h00f0);
      rd_reg(8'h08, 16'h00f1);
      wr_reg(8'h20, 16'h000f);
      wr_reg(8'h00, 16'hffff);
      `CHK("pend", 16'hff0e, pend)
      u_cmsf_engine_model.send(4'h1);
      `CHK("pend", 16'hff0c, pend)
      `CHK("irq", 1'b1, irq)
      rd_reg(8'h0c, 16'h0002);
      rd_reg(8'h1c, 16'h0001);
      `CHK("irq", 1'b0, irq)
      u_cmsf_engine_model.send(4'h4);
      rd_reg(8'h0c, 16'h0002);
      wr_reg(8'h04, 16'h000d);
      `CHK("canc", 16'h000c, canc)
      u_cmsf_engine_model.abort(4'h2);
      rd_reg(8'h10, 16'h0004);
      `CHK("canc", 16'h0008, canc)
      fork
         u_cmsf_engine_model.send(4'h3);
         u_cmsf_engine_model.abort(4'h3);
      join
      `CHK("pend", 16'hff00, pend)
      `CHK("canc", 16'h0000, canc)
      u_cmsf_engine_model.abort(4'h8);
      rd_reg(8'h10, 16'h0004);
      rd_reg(8'h0c, 16'h000a);
      wr_reg(8'h0c, 16'h0002);
      rd_reg(8'h0c, 16'h0008);
      wr_reg(8'h10, 16'h0000);
      rd_reg(8'h10, 16'h0004);
      wr_reg(8'h10, 16'hffff);
      rd_reg(8'h10, 16'h0000);
      u_cmsf_engine_model.recv(4'h4, 1'b0);
      u_cmsf_engine_model.recv(4'h5, 1'b1);
      u_cmsf_engine_model.recv(4'h0, 1'b0);
      u_cmsf_engine_model.recv(4'h8, 1'b1);
      rd_reg(8'h14, 16'h0031);
      rd_reg(8'h18, 16'h0020);
      wr_reg(8'h18, 16'h0020);
      rd_reg(8'h18, 16'h0000);
      rd_reg(8'h14, 16'h0031);
      rd_reg(8'h1c, 16'h000f);
      wr_reg(8'h20, 16'h0000);
      u_cmsf_engine_model.recv(4'h6, 1'b1);
      `CHK("irq", 1'b0, irq)
      wr_reg(8'h20, 16'h0008);
      `CHK("irq", 1'b1, irq)
      rd_reg(8'h1c, 16'h000c);
      `CHK("irq", 1'b0, irq)
      wr_reg(8'h40, 16'hffff);
      rd_reg(8'h40, 16'h0000);
      rd_reg(8'h08, 16'h00f1);
      wr_reg(8'h04, 16'h0002);
      `CHK("canc", 16'h0000, canc)
      finish_test();
   end
endmodule : cmsf_top_test
